// ===== logic/nfh_pkg.sv
// Package for the flash host sequencer: opcodes, timing, state and pin types
package nfh_pkg;

    // Opcodes issued by the host
    localparam logic [7:0] OP_READ_SETUP   = 8'h00;
    localparam logic [7:0] OP_READ_CONFIRM = 8'h30;
    localparam logic [7:0] OP_RAND_OUT     = 8'h05;
    localparam logic [7:0] OP_RAND_OUT_CNF = 8'he0;
    localparam logic [7:0] OP_CACHE_CNF    = 8'h31;
    localparam logic [7:0] OP_CACHE_EXIT   = 8'h34;
    localparam logic [7:0] OP_PROG_SETUP   = 8'h80;
    localparam logic [7:0] OP_PROG_CONFIRM = 8'h10;
    localparam logic [7:0] OP_RAND_IN      = 8'h85;
    localparam logic [7:0] OP_COPY_CNF     = 8'h35;
    localparam logic [7:0] OP_RESET        = 8'hff;
    localparam logic [7:0] OP_READ_ID      = 8'h90;
    localparam logic [7:0] OP_STATUS       = 8'h70;
    localparam logic [7:0] OP_LOCK_STATUS  = 8'h7a;
    localparam logic [7:0] OP_UNLOCK_LO    = 8'h23;
    localparam logic [7:0] OP_UNLOCK_HI    = 8'h24;
    localparam logic [7:0] OP_LOCK         = 8'h2a;
    localparam logic [7:0] OP_LOCK_DOWN    = 8'h2c;

    // Status bit positions
    localparam int SR_ARRAY_DONE_BIT = 5;
    localparam int SR_CACHE_RDY_BIT  = 6;

    // Software register map (word index = address)
    localparam logic [3:0] ADDR_CTRL   = 4'h0;
    localparam logic [3:0] ADDR_ROW    = 4'h1;
    localparam logic [3:0] ADDR_COL    = 4'h2;
    localparam logic [3:0] ADDR_DATA   = 4'h3;
    localparam logic [3:0] ADDR_STATUS = 4'h4;
    localparam logic [3:0] ADDR_COUNT  = 4'h5;

    // Control word actions (bits 3:0 of CTRL write)
    localparam logic [3:0] ACT_CMD     = 4'h1;
    localparam logic [3:0] ACT_ADDR5   = 4'h2;
    localparam logic [3:0] ACT_ADDR2   = 4'h3;
    localparam logic [3:0] ACT_WDATA   = 4'h4;
    localparam logic [3:0] ACT_RDATA   = 4'h5;
    localparam logic [3:0] ACT_WAITRDY = 4'h6;

    // Reset values
    localparam logic [11:0] COL_RST  = 12'h000;
    localparam logic [18:0] ROW_RST  = 19'h00000;

    // Pin timing: each strobe phase is at least 20 ns, well over the 5 ns glitch floor
    localparam int CLK_PERIOD_NS  = 40;
    localparam int PHASE_NS       = 20;
    localparam int PHASE_CYC_RAW  = (PHASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0] PHASE_CYC = (PHASE_CYC_RAW < 1) ? 4'h1 : 4'(PHASE_CYC_RAW);
    // Ready/busy may fall some time after the confirm edge
    localparam int BUSY_WAIT_NS   = 100;
    localparam logic [3:0] BUSY_WAIT_CYC = 4'(BUSY_WAIT_NS / CLK_PERIOD_NS);
    localparam int ADDR_CYCLES    = 5;

    // Pins driven toward the flash
    typedef struct packed {
        logic       chip_sel_n;
        logic       cmd_cycle_select;
        logic       addr_cycle_select;
        logic       write_strobe_n;
        logic       read_strobe_n;
        logic       write_protect_n;
        logic [7:0] bus_out;
        logic       bus_oe_n;
    } nfh_pins_t;

    typedef enum logic [5:0] {
        ST_IDLE  = 6'b000001,
        ST_SETUP = 6'b000010,
        ST_LOW   = 6'b000100,
        ST_HIGH  = 6'b001000,
        ST_BUSYW = 6'b010000,
        ST_RDYW  = 6'b100000
    } nfh_state_t;

endpackage : nfh_pkg

// ===== logic/nfh_host.sv
// Host-side sequencer that drives a large-page flash over its byte bus
//
// Local design decisions: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module nfh_host
(
    // Clock and reset
    input  wire logic        CLK_SYS,
    input  wire logic        RST_N,
    // Software register port
    input  wire logic [3:0]  ADDR,
    input  wire logic [31:0] WDATA,
    input  wire logic        WR,
    input  wire logic        RD,
    output logic      [31:0] RDATA,
    // Flash pins
    output logic             CHIP_SEL_N,
    output logic             CMD_CYCLE_SELECT,
    output logic             ADDR_CYCLE_SELECT,
    output logic             WRITE_STROBE_N,
    output logic             READ_STROBE_N,
    output logic             WRITE_PROTECT_N,
    output logic      [7:0]  SHARED_BUS_BYTE_O,
    output logic             SHARED_BUS_BYTE_OE_N,
    input  wire logic [7:0]  SHARED_BUS_BYTE_I,
    input  wire logic        READY_BUSY_N
);

    // Control word fields: [3:0] action, [11:4] opcode or data, [12] WRITE_PROTECT_N level
    nfh_pkg::nfh_pins_t  pins_reg,    pins_next;
    nfh_pkg::nfh_state_t state_reg,   state_next;
    logic [3:0]          act_reg,     act_next;
    logic [7:0]          byte_reg,    byte_next;
    logic [2:0]          idx_reg,     idx_next;
    logic [3:0]          tmr_reg,     tmr_next;
    logic [11:0]         col_reg,     col_next;
    logic [18:0]         row_reg,     row_next;
    logic [7:0]          rbyte_reg,   rbyte_next;
    logic [15:0]         rcount_reg,  rcount_next;
    logic                wp_reg,      wp_next;
    logic                cache_reg,   cache_next;
    logic                refused_reg, refused_next;
    logic [31:0]         rdata_reg,   rdata_next;
    logic [2:0]          rb_sync_reg;
    logic [2:0]          rb_sync_next;
    logic                rb_ready_reg, rb_ready_next;
    logic [2:0]          last_idx;
    logic [7:0]          addr_byte;
    logic                busy;

    assign busy = (state_reg != nfh_pkg::ST_IDLE);

    // Address byte layout with unused high bits forced low
    always_comb
    begin
        unique case (idx_reg)
            3'h0:    addr_byte = col_reg[7:0];
            3'h1:    addr_byte = {4'h0, col_reg[11:8]};
            3'h2:    addr_byte = row_reg[7:0];
            3'h3:    addr_byte = row_reg[15:8];
            default: addr_byte = {5'h00, row_reg[18:16]};
        endcase
    end

    assign last_idx = (act_reg == nfh_pkg::ACT_ADDR5) ? 3'(nfh_pkg::ADDR_CYCLES - 1) : 3'h1;

    // Ready/busy is asynchronous: three stages, change taken when the last two agree
    always_comb
    begin
        rb_sync_next  = {rb_sync_reg[1:0], READY_BUSY_N};
        rb_ready_next = rb_ready_reg;
        if (rb_sync_reg[2] == rb_sync_reg[1])
        begin
            rb_ready_next = rb_sync_reg[2];
        end
    end

    always_comb
    begin
        state_next   = state_reg;
        pins_next    = pins_reg;
        act_next     = act_reg;
        byte_next    = byte_reg;
        idx_next     = idx_reg;
        tmr_next     = tmr_reg;
        col_next     = col_reg;
        row_next     = row_reg;
        rbyte_next   = rbyte_reg;
        rcount_next  = rcount_reg;
        wp_next      = wp_reg;
        cache_next   = cache_reg;
        refused_next = refused_reg;
        rdata_next   = 32'h00000000;

        if (RD)
        begin
            unique case (ADDR)
                nfh_pkg::ADDR_CTRL:   rdata_next = {19'h00000, wp_reg, byte_reg, act_reg};
                nfh_pkg::ADDR_ROW:    rdata_next = {13'h0000, row_reg};
                nfh_pkg::ADDR_COL:    rdata_next = {20'h00000, col_reg};
                nfh_pkg::ADDR_DATA:   rdata_next = {24'h000000, rbyte_reg};
                nfh_pkg::ADDR_STATUS: rdata_next = {28'h0000000, refused_reg, cache_reg,
                                                    rb_ready_reg, busy};
                nfh_pkg::ADDR_COUNT:  rdata_next = {16'h0000, rcount_reg};
                default:              rdata_next = 32'h00000000;
            endcase
        end

        if (WR && !busy)
        begin
            unique case (ADDR)
                nfh_pkg::ADDR_ROW:
                begin
                    // The top block bit may not move while a cache read runs
                    row_next = cache_reg ? {row_reg[18], WDATA[17:0]} : WDATA[18:0];
                end
                nfh_pkg::ADDR_COL: col_next = WDATA[11:0];
                nfh_pkg::ADDR_CTRL:
                begin
                    wp_next  = WDATA[12];
                    act_next = WDATA[3:0];
                    byte_next = WDATA[11:4];
                    // A random data output inside cache read would be refused by the device
                    if (WDATA[3:0] == nfh_pkg::ACT_CMD && WDATA[11:4] == nfh_pkg::OP_RAND_OUT
                        && cache_reg)
                    begin
                        refused_next = 1'b1;
                    end
                    else if (WDATA[3:0] == nfh_pkg::ACT_WAITRDY)
                    begin
                        refused_next = 1'b0;
                        tmr_next     = nfh_pkg::BUSY_WAIT_CYC;
                        state_next   = nfh_pkg::ST_BUSYW;
                    end
                    else if (WDATA[3:0] >= nfh_pkg::ACT_CMD && WDATA[3:0] <= nfh_pkg::ACT_RDATA)
                    begin
                        refused_next = 1'b0;
                        idx_next     = 3'h0;
                        tmr_next     = nfh_pkg::PHASE_CYC;
                        state_next   = nfh_pkg::ST_SETUP;
                        if (WDATA[3:0] == nfh_pkg::ACT_CMD)
                        begin
                            if (WDATA[11:4] == nfh_pkg::OP_CACHE_CNF)
                            begin
                                cache_next = 1'b1;
                            end
                            else if (WDATA[11:4] == nfh_pkg::OP_CACHE_EXIT
                                     || WDATA[11:4] == nfh_pkg::OP_RESET)
                            begin
                                cache_next = 1'b0;
                            end
                        end
                    end
                end
                default: ;
            endcase
        end

        pins_next.write_protect_n = wp_reg;
        unique case (state_reg)
            nfh_pkg::ST_IDLE:
            begin
                pins_next.chip_sel_n        = 1'b1;
                pins_next.cmd_cycle_select  = 1'b0;
                pins_next.addr_cycle_select = 1'b0;
                pins_next.write_strobe_n    = 1'b1;
                pins_next.read_strobe_n     = 1'b1;
                pins_next.bus_oe_n          = 1'b1;
            end
            nfh_pkg::ST_SETUP:
            begin
                // Latch selects and data settle before the strobe falls
                pins_next.chip_sel_n        = 1'b0;
                pins_next.read_strobe_n     = 1'b1;
                pins_next.write_strobe_n    = 1'b1;
                pins_next.cmd_cycle_select  = (act_reg == nfh_pkg::ACT_CMD);
                pins_next.addr_cycle_select = (act_reg == nfh_pkg::ACT_ADDR5
                                               || act_reg == nfh_pkg::ACT_ADDR2);
                pins_next.bus_oe_n          = (act_reg == nfh_pkg::ACT_RDATA);
                pins_next.bus_out           = pins_next.addr_cycle_select ? addr_byte : byte_reg;
                if (tmr_reg <= 4'h1)
                begin
                    tmr_next   = nfh_pkg::PHASE_CYC;
                    state_next = nfh_pkg::ST_LOW;
                end
                else
                begin
                    tmr_next = tmr_reg - 4'h1;
                end
            end
            nfh_pkg::ST_LOW:
            begin
                // Strobe low for whole phase, never a short pulse
                if (act_reg == nfh_pkg::ACT_RDATA)
                begin
                    pins_next.read_strobe_n = 1'b0;
                end
                else
                begin
                    pins_next.write_strobe_n = 1'b0;
                end
                if (tmr_reg <= 4'h1)
                begin
                    tmr_next   = nfh_pkg::PHASE_CYC;
                    state_next = nfh_pkg::ST_HIGH;
                end
                else
                begin
                    tmr_next = tmr_reg - 4'h1;
                end
            end
            nfh_pkg::ST_HIGH:
            begin
                pins_next.write_strobe_n = 1'b1;
                pins_next.read_strobe_n  = 1'b1;
                if (act_reg == nfh_pkg::ACT_RDATA && tmr_reg == nfh_pkg::PHASE_CYC)
                begin
                    // Taken at the edge that raises the read strobe: the byte has stood
                    // since the strobe fell, while an extra input flop would still be stale
                    rbyte_next  = SHARED_BUS_BYTE_I;
                    rcount_next = rcount_reg + 16'h0001;
                end
                if (tmr_reg <= 4'h1)
                begin
                    if ((act_reg == nfh_pkg::ACT_ADDR5 || act_reg == nfh_pkg::ACT_ADDR2)
                        && idx_reg != last_idx)
                    begin
                        idx_next   = idx_reg + 3'h1;
                        tmr_next   = nfh_pkg::PHASE_CYC;
                        state_next = nfh_pkg::ST_SETUP;
                    end
                    else
                    begin
                        state_next = nfh_pkg::ST_IDLE;
                    end
                end
                else
                begin
                    tmr_next = tmr_reg - 4'h1;
                end
            end
            nfh_pkg::ST_BUSYW:
            begin
                // Give the device time to pull busy low after a confirm
                if (tmr_reg <= 4'h1)
                begin
                    state_next = nfh_pkg::ST_RDYW;
                end
                else
                begin
                    tmr_next = tmr_reg - 4'h1;
                end
            end
            nfh_pkg::ST_RDYW:
            begin
                if (rb_ready_reg)
                begin
                    rcount_next = 16'h0000;
                    state_next  = nfh_pkg::ST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge CLK_SYS or negedge RST_N)
    begin
        if (!RST_N)
        begin
            state_reg    <= nfh_pkg::ST_IDLE;
            pins_reg     <= '{chip_sel_n: 1'b1, cmd_cycle_select: 1'b0, addr_cycle_select: 1'b0,
                              write_strobe_n: 1'b1, read_strobe_n: 1'b1, write_protect_n: 1'b0,
                              bus_out: 8'h00, bus_oe_n: 1'b1};
            act_reg      <= 4'h0;
            byte_reg     <= 8'h00;
            idx_reg      <= 3'h0;
            tmr_reg      <= 4'h0;
            col_reg      <= nfh_pkg::COL_RST;
            row_reg      <= nfh_pkg::ROW_RST;
            rbyte_reg    <= 8'h00;
            rcount_reg   <= 16'h0000;
            wp_reg       <= 1'b0;
            cache_reg    <= 1'b0;
            refused_reg  <= 1'b0;
            rdata_reg    <= 32'h00000000;
            rb_sync_reg  <= 3'h7;
            rb_ready_reg <= 1'b1;
        end
        else
        begin
            state_reg    <= state_next;
            pins_reg     <= pins_next;
            act_reg      <= act_next;
            byte_reg     <= byte_next;
            idx_reg      <= idx_next;
            tmr_reg      <= tmr_next;
            col_reg      <= col_next;
            row_reg      <= row_next;
            rbyte_reg    <= rbyte_next;
            rcount_reg   <= rcount_next;
            wp_reg       <= wp_next;
            cache_reg    <= cache_next;
            refused_reg  <= refused_next;
            rdata_reg    <= rdata_next;
            rb_sync_reg  <= rb_sync_next;
            rb_ready_reg <= rb_ready_next;
        end
    end

    assign RDATA                = rdata_reg;
    assign CHIP_SEL_N           = pins_reg.chip_sel_n;
    assign CMD_CYCLE_SELECT     = pins_reg.cmd_cycle_select;
    assign ADDR_CYCLE_SELECT    = pins_reg.addr_cycle_select;
    assign WRITE_STROBE_N       = pins_reg.write_strobe_n;
    assign READ_STROBE_N        = pins_reg.read_strobe_n;
    assign WRITE_PROTECT_N      = pins_reg.write_protect_n;
    assign SHARED_BUS_BYTE_O    = pins_reg.bus_out;
    assign SHARED_BUS_BYTE_OE_N = pins_reg.bus_oe_n;

    cmd_latch_sel_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        $rose(WRITE_STROBE_N) && CMD_CYCLE_SELECT |->
            !CHIP_SEL_N && !ADDR_CYCLE_SELECT && READ_STROBE_N)
        else $error("command latched with wrong select levels");
    addr_latch_sel_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        $rose(WRITE_STROBE_N) && ADDR_CYCLE_SELECT |->
            !CHIP_SEL_N && !CMD_CYCLE_SELECT && READ_STROBE_N)
        else $error("address latched with wrong select levels");
    data_latch_sel_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        $rose(WRITE_STROBE_N) && !CMD_CYCLE_SELECT && !ADDR_CYCLE_SELECT |->
            !CHIP_SEL_N && READ_STROBE_N && !SHARED_BUS_BYTE_OE_N)
        else $error("data latched with wrong levels");
    read_out_sel_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        !READ_STROBE_N |-> WRITE_STROBE_N && !CMD_CYCLE_SELECT && !ADDR_CYCLE_SELECT
            && SHARED_BUS_BYTE_OE_N && !CHIP_SEL_N)
        else $error("read strobe with bus driven or selects high");
    strobe_width_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        $fell(WRITE_STROBE_N) |-> !WRITE_STROBE_N [*1] ##1 $rose(WRITE_STROBE_N) or
            (!WRITE_STROBE_N ##1 !WRITE_STROBE_N))
        else $error("write strobe pulse too short");
    addr_upper_zero_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        $fell(WRITE_STROBE_N) && ADDR_CYCLE_SELECT && idx_reg == 3'h1 |->
            SHARED_BUS_BYTE_O[7:4] == 4'h0)
        else $error("unused column address bits not low");
    addr_five_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        $fell(ADDR_CYCLE_SELECT) && act_reg == nfh_pkg::ACT_ADDR5 |-> $past(idx_reg) == 3'h4)
        else $error("address group did not carry five bytes");
    wp_follow_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        ##1 WRITE_PROTECT_N == $past(wp_reg))
        else $error("write protect pin not following control");
    idle_standby_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        $past(state_reg) == nfh_pkg::ST_IDLE |-> CHIP_SEL_N && SHARED_BUS_BYTE_OE_N)
        else $error("idle but device selected");
    rand_refuse_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        cache_reg && !busy && WR && ADDR == nfh_pkg::ADDR_CTRL
            && WDATA[3:0] == nfh_pkg::ACT_CMD && WDATA[11:4] == nfh_pkg::OP_RAND_OUT
            |=> refused_reg && !busy)
        else $error("random output not refused in cache read");

endmodule : nfh_host
`default_nettype wire

// ===== verification/nfh_flash_model.sv
// Behavioural byte-bus flash device seen by the host sequencer
`timescale 1ns/1ps
`default_nettype none
module nfh_flash_model
#(parameter int LOAD_NS = 2000)
(
    // Strobes and selects from the host
    input  wire logic       cs_n,
    input  wire logic       cle,
    input  wire logic       ale,
    input  wire logic       we_n,
    input  wire logic       re_n,
    // Host byte and its enable
    input  wire logic [7:0] host_byte,
    input  wire logic       host_oe_n,
    // Resolved bus and open-drain ready
    output logic      [7:0] bus,
    output logic            rb_n
);
    logic [7:0]  ab [5];
    logic [7:0]  q = 8'h00;
    logic [18:0] row = 19'h00000;
    logic [11:0] col = 12'h000;
    int          acnt = 0;
    realtime     t_we = 0;
    logic        busy = 0, fetch = 0, cache = 0, stat = 0, qv = 0;
    function automatic logic [7:0] pat(input logic [18:0] r, input logic [11:0] c);
        return r[7:0] + c[7:0] + {4'h0, c[11:8]};
    endfunction : pat
    // Pull-up holds the line high unless a page load is running
    assign rb_n = !busy;
    // A released bus shows the inverse of the last byte, never a stale copy
    assign bus = (qv && !cs_n && we_n && !ale && !cle) ? q : (!host_oe_n ? host_byte : ~q);
    always @(negedge we_n) t_we = $realtime;
    // A write strobe low for under 5 ns is a glitch and latches nothing
    always @(posedge we_n)
        if ($realtime - t_we < 5.0) ;
        else if (!cs_n && re_n && ale && !cle)
        begin
            if (acnt < 5) ab[acnt] = host_byte;
            acnt++;
        end
        else if (!cs_n && re_n && cle && !ale && (!busy || host_byte inside {8'hff, 8'h70}
                 || (host_byte == 8'h34 && cache)))
        begin
            qv = 0;
            // Each accepted command starts a fresh address group
            acnt = 0;
            case (host_byte)
                8'h00: {acnt, stat} = '0;
                8'h30, 8'h31:
                begin
                    col = {ab[1][3:0], ab[0]};
                    row = {ab[4][2:0], ab[3], ab[2]};
                    cache = host_byte[0];
                    acnt = 0;
                    fork
                    begin
                        busy = 1;
                        #LOAD_NS busy = 0;
                        fetch = cache;
                        #LOAD_NS fetch = 0;
                    end
                    join_none
                end
                8'h05: if (!cache) acnt = 0;
                8'he0: if (!cache) col = {ab[1][3:0], ab[0]};
                8'h34: cache = 0;
                8'h70: stat = 1;
                8'hff: {cache, stat, acnt} = '0;
                default: ;
            endcase
        end
    always @(negedge re_n)
        if (!cs_n && we_n && !ale && !cle)
        begin
            q = stat ? {1'b0, !busy, !(busy || fetch), 5'h0} : pat(row, col);
            qv = 1;
            if (!stat) col++;
            if (cache && col == 12'd2112) {row, col} = {row + 19'd1, 12'h000};
        end
endmodule : nfh_flash_model
`default_nettype wire

// ===== verification/nfh_host_tb.sv
// Self-checking bench for the flash host sequencer against the device model
`timescale 1ns/1ps
`default_nettype none
module nfh_host_tb;
    logic        clk, rst_n, wr, rd, chk, chk_d, cs_n, cle, ale, we_n, re_n, wp_n, oe_n, rb_n;
    logic [3:0]  addr;
    logic [31:0] wdata, rdata, v;
    logic [31:0] exp_q [$];
    logic [7:0]  bo, bi;
    logic [18:0] row;
    logic [11:0] col;
    int          n_errors, n_checks, seed, i, k;
    nfh_host i_dut (.CLK_SYS(clk), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata), .WR(wr),
        .RD(rd), .RDATA(rdata), .CHIP_SEL_N(cs_n), .CMD_CYCLE_SELECT(cle),
        .ADDR_CYCLE_SELECT(ale), .WRITE_STROBE_N(we_n), .READ_STROBE_N(re_n),
        .WRITE_PROTECT_N(wp_n), .SHARED_BUS_BYTE_O(bo), .SHARED_BUS_BYTE_OE_N(oe_n),
        .SHARED_BUS_BYTE_I(bi), .READY_BUSY_N(rb_n));
    nfh_flash_model i_flash (.cs_n(cs_n), .cle(cle), .ale(ale), .we_n(we_n), .re_n(re_n),
        .host_byte(bo), .host_oe_n(oe_n), .bus(bi), .rb_n(rb_n));
    function automatic logic [7:0] expb(input logic [18:0] r, input logic [11:0] c);
        return r[7:0] + c[7:0] + {4'h0, c[11:8]};
    endfunction : expb
    task automatic check(input logic [31:0] seen, input logic [31:0] e);
        n_checks++;
        if (seen !== e)
        begin
            n_errors++;
            $display("Error at %0t: got %h, expected %h", $time, seen, e);
        end
    endtask : check
    task automatic final_report();
        $display("checks %0d, mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : final_report
    task automatic wreg(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wreg
    // Expected value is queued here and compared by the watcher below
    task automatic rreg(input logic [3:0] a, input logic c, input logic [31:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        chk <= c;
        if (c) exp_q.push_back(e);
        @(posedge clk);
        rd <= 1'b0;
        #1 v = rdata;
    endtask : rreg
    task automatic act(input logic [7:0] op, input logic [3:0] a);
        wreg(nfh_pkg::ADDR_CTRL, {19'h0, 1'b1, op, a});
        for (k = 0; k < 400; k++)
        begin
            rreg(nfh_pkg::ADDR_STATUS, 1'b0, 32'h0);
            if (v[0] === 1'b0) break;
        end
        if (k == 400)
        begin
            n_errors++;
            $display("Error at %0t: sequencer stuck busy", $time);
            final_report();
        end
    endtask : act
    task automatic rbyte(input logic [7:0] e);
        act(8'h00, nfh_pkg::ACT_RDATA);
        rreg(nfh_pkg::ADDR_DATA, 1'b1, {24'h0, e});
    endtask : rbyte
    task automatic load(input logic [7:0] cnf);
        wreg(nfh_pkg::ADDR_ROW, {13'h0, row});
        wreg(nfh_pkg::ADDR_COL, {20'h0, col});
        act(8'h00, nfh_pkg::ACT_ADDR5);
        wreg(nfh_pkg::ADDR_COL, 32'h0000_0abc);
        act(8'h00, nfh_pkg::ACT_ADDR2);
        act(cnf, nfh_pkg::ACT_CMD);
        act(8'h00, nfh_pkg::ACT_WAITRDY);
    endtask : load
    always @(posedge clk) chk_d <= rd && chk;
    always @(negedge clk) if (chk_d) check(rdata, exp_q.pop_front());
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    initial
    begin
        seed = 32'he42faa6d;
        {rst_n, wr, rd, chk, addr, wdata, n_errors, n_checks} = '0;
        repeat (4) @(posedge clk);
        check({30'h0, cs_n, wp_n}, 32'h2);
        rst_n <= 1'b1;
        rreg(4'hf, 1'b1, 32'h0);
        row = 19'($random(seed));
        col = 12'($unsigned($random(seed)) % 2000);
        act(8'h5a, nfh_pkg::ACT_WDATA);
        rreg(nfh_pkg::ADDR_CTRL, 1'b1, 32'h0000_15a4);
        act(nfh_pkg::OP_READ_SETUP, nfh_pkg::ACT_CMD);
        load(nfh_pkg::OP_READ_CONFIRM);
        for (i = 0; i < 4; i++) rbyte(expb(row, 12'(col + i)));
        rreg(nfh_pkg::ADDR_COUNT, 1'b1, 32'h4);
        check({31'h0, cs_n}, 32'h1);
        $display("page read test done");
        for (i = 0; i < 2; i++)
        begin
            col = 12'($unsigned($random(seed)) % 2000);
            act(nfh_pkg::OP_RAND_OUT, nfh_pkg::ACT_CMD);
            wreg(nfh_pkg::ADDR_COL, {20'h0, col});
            act(8'h00, nfh_pkg::ACT_ADDR2);
            act(nfh_pkg::OP_RAND_OUT_CNF, nfh_pkg::ACT_CMD);
            rbyte(expb(row, col));
            rbyte(expb(row, 12'(col + 1)));
        end
        $display("random output test done");
        row = 19'($random(seed));
        col = 12'h7ff;
        load(nfh_pkg::OP_READ_CONFIRM);
        rbyte(expb(row, col));
        $display("confirm-only read test done");
        col = 12'h000;
        act(nfh_pkg::OP_READ_SETUP, nfh_pkg::ACT_CMD);
        load(nfh_pkg::OP_CACHE_CNF);
        act(nfh_pkg::OP_STATUS, nfh_pkg::ACT_CMD);
        rbyte(8'h40);
        act(nfh_pkg::OP_READ_SETUP, nfh_pkg::ACT_CMD);
        rbyte(expb(row, 12'h000));
        act(nfh_pkg::OP_RAND_OUT, nfh_pkg::ACT_CMD);
        rreg(nfh_pkg::ADDR_STATUS, 1'b1, 32'he);
        wreg(nfh_pkg::ADDR_ROW, {13'h0, ~row[18], row[17:0]});
        rreg(nfh_pkg::ADDR_ROW, 1'b1, {13'h0, row});
        repeat (120) @(posedge clk);
        act(nfh_pkg::OP_STATUS, nfh_pkg::ACT_CMD);
        rbyte(8'h60);
        act(nfh_pkg::OP_CACHE_EXIT, nfh_pkg::ACT_CMD);
        rreg(nfh_pkg::ADDR_STATUS, 1'b0, 32'h0);
        check({29'h0, v[2:0]}, 32'h2);
        $display("cache read test done");
        final_report();
    end
endmodule : nfh_host_tb
`default_nettype wire
